// [src/dimmer_seq_pkg.sv]
package dimmer_seq_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_MS;
  localparam int unsigned SECS_PER_DAY    = 86400;

  // -----------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------
  localparam int unsigned NUM_STEPS       = 32;
  localparam int unsigned FULL_SCALE      = 255;

  // -----------------------------------------------------------------
  // register map (word aligned byte offsets)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCK_CFG    = 8'h00;
  localparam logic [7:0] ADDR_SEQ_CFG     = 8'h04;
  localparam logic [7:0] ADDR_SEQ_CFG2    = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0c;
  localparam logic [7:0] ADDR_STEP_SEL    = 8'h10;
  localparam logic [7:0] ADDR_STEP_W0     = 8'h14;
  localparam logic [7:0] ADDR_STEP_W1     = 8'h18;
  localparam logic [7:0] ADDR_TIME        = 8'h1c;

  localparam logic [31:0] RESET_LOCK_CFG  = 32'h0000_0001;
  localparam logic [31:0] RESET_SEQ_CFG   = 32'h0000_0000;
  localparam logic [31:0] RESET_SEQ_CFG2  = 32'h0000_0000;

  // -----------------------------------------------------------------
  // enumerations
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    END_NONE, END_DIM, END_RESTORE, END_LAST
  } lock_end_type;

  typedef enum logic [1:0] {
    RES_OBJECT, RES_OFFTIME, RES_NEXT_STEP
  } resume_mode_type;

  typedef enum logic [1:0] {
    OFF_COMPLETE, OFF_STEP, OFF_STOP
  } off_mode_type;

  typedef enum logic [1:0] {
    START_NONE, START_TIME, START_WAIT
  } time_start_type;

  typedef enum logic [1:0] {
    ACT_NONE, ACT_LOOP, ACT_SCENE, ACT_BRIGHT
  } action_type;

  // step configuration word pair
  typedef struct packed {
    time_start_type time_mode;
    logic           tel_en;
    logic           scene_en;
    logic [5:0]     scene_in;
    action_type     action;
    logic [4:0]     loop_to;
    logic [5:0]     loop_cnt;   // six bits keep a step inside two words
    logic [7:0]     param;
    logic [16:0]    start_sec;
    logic [15:0]    fade_ticks;
  } step_cfg_type;

  // group-object telegram inputs
  typedef struct packed {
    logic        normal_valid;
    logic [7:0]  normal_value;
    logic        manual;
    logic        lock_valid;
    logic        lock_value;
    logic        prio_valid;
    logic [7:0]  prio_value;
    logic        suspend_valid;
    logic        suspend_value;
    logic        onoff_valid;
    logic        onoff_value;
    logic        step_valid;
    logic [4:0]  step_index;
    logic        step_value;
    logic        scene_valid;
    logic [5:0]  scene_value;
    logic        time_valid;
    logic [16:0] time_value;
  } telegram_type;

endpackage

// [src/dimmer_seq.sv]
module dimmer_seq
  import dimmer_seq_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // telegrams
  input  wire telegram_type tel,
  // outputs
  output logic [7:0]       brightness,
  output logic             scene_out_valid,
  output logic [5:0]       scene_out
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] lock_cfg;
    logic [31:0] seq_cfg;
    logic [31:0] seq_cfg2;
    logic [4:0]  step_sel;
    logic [23:0] tick_div;
    logic        tick;
    logic [6:0]  sub_sec;
    logic [16:0] tod;
    logic        tod_valid;
    logic        locked;
    logic [7:0]  saved;
    logic [7:0]  last_tel;
    logic        last_seen;
    logic [7:0]  level;
    logic [7:0]  target;
    logic [15:0] fade_ticks;
    logic [15:0] fade_acc;
    logic        seq_on;
    logic        running;
    logic        suspended;
    logic [4:0]  cur;
    logic [31:0] wait_cnt;
    logic [31:0] off_cnt;
    logic [7:0]  loops_done;
    logic        scene_v;
    logic [5:0]  scene;
  } state_type;

  state_type    s, next_s;
  step_cfg_type steps [NUM_STEPS];
  logic [63:0]  step_raw [NUM_STEPS];

  function automatic step_cfg_type unpack_step(input logic [63:0] raw);
    unpack_step = step_cfg_type'(raw[$bits(step_cfg_type)-1:0]);
  endfunction

  // lock config fields
  logic         lock_pol;
  logic         start_dim;
  lock_end_type end_mode;
  logic [7:0]   start_val, end_val;
  assign lock_pol  = s.lock_cfg[0];
  assign start_dim = s.lock_cfg[1];
  assign end_mode  = lock_end_type'(s.lock_cfg[3:2]);
  assign start_val = s.lock_cfg[15:8];
  assign end_val   = s.lock_cfg[23:16];

  // sequencer config fields
  logic [5:0]      num_steps;
  resume_mode_type res_mode;
  logic [4:0]      res_step;
  logic            onoff_pol;
  logic            on_run;
  logic [4:0]      on_step;
  off_mode_type    off_mode;
  logic [4:0]      off_step;
  assign num_steps = (s.seq_cfg[5:0] > 6'd32) ? 6'd32 : s.seq_cfg[5:0];
  assign res_mode  = resume_mode_type'(s.seq_cfg[7:6]);
  assign res_step  = s.seq_cfg[12:8];
  assign onoff_pol = s.seq_cfg[13];
  assign on_run    = s.seq_cfg[14];
  assign on_step   = s.seq_cfg[19:15];
  assign off_mode  = off_mode_type'(s.seq_cfg[21:20]);
  assign off_step  = s.seq_cfg[26:22];

  // -----------------------------------------------------------------
  // step memory
  // -----------------------------------------------------------------
  logic wr_fire;
  assign wr_fire = s.aw_got && s.w_got && !s.bvalid;

  always_ff @(posedge aclk) begin
    if (wr_fire && s.aw_addr == ADDR_STEP_W0)
      step_raw[s.step_sel][31:0] <= s.w_data;
    if (wr_fire && s.aw_addr == ADDR_STEP_W1)
      step_raw[s.step_sel][63:32] <= s.w_data;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_STEPS; g++) begin : g_step
      assign steps[g] = unpack_step(step_raw[g]);
    end
  endgenerate

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic         act;
    logic         uncond;
    logic [4:0]   act_idx;
    logic         lock_evt;
    logic         seq_rst;
    step_cfg_type st;
    logic [15:0]  acc;
    next_s = s;
    act = 1'b0;
    uncond = 1'b0;
    act_idx = 5'd0;
    lock_evt = 1'b0;
    seq_rst = 1'b0;
    st = steps[0];
    acc = 16'd0;
    next_s.scene_v = 1'b0;

    // bus slave; reads answer one cycle after address
    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
    end
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = 2'b00;
      case (s.aw_addr)
        ADDR_LOCK_CFG: next_s.lock_cfg = s.w_data;
        ADDR_SEQ_CFG:  next_s.seq_cfg  = s.w_data;
        ADDR_SEQ_CFG2: next_s.seq_cfg2 = s.w_data;
        ADDR_STEP_SEL: next_s.step_sel = s.w_data[4:0];
        ADDR_STEP_W0, ADDR_STEP_W1: ;
        default:       next_s.bresp  = 2'b10;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = 2'b00;
      case (s_axi_araddr)
        ADDR_LOCK_CFG: next_s.rdata = s.lock_cfg;
        ADDR_SEQ_CFG:  next_s.rdata = s.seq_cfg;
        ADDR_SEQ_CFG2: next_s.rdata = s.seq_cfg2;
        ADDR_STATUS:   next_s.rdata = {8'h00, s.level, 3'b000, s.cur,
                                       3'b000, s.tod_valid, s.suspended,
                                       s.running, s.seq_on, s.locked};
        ADDR_STEP_SEL: next_s.rdata = {27'h0, s.step_sel};
        ADDR_STEP_W0:  next_s.rdata = step_raw[s.step_sel][31:0];
        ADDR_STEP_W1:  next_s.rdata = step_raw[s.step_sel][63:32];
        ADDR_TIME:     next_s.rdata = {14'h0, s.tod_valid, s.tod};
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = 2'b10;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;

    // tick divider and time of day
    next_s.tick = 1'b0;
    if (s.tick_div == 24'(TICK_CYCLES - 1)) begin
      next_s.tick_div = 24'd0;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_div = s.tick_div + 24'd1;
    end
    if (s.tick) begin
      if (s.sub_sec == 7'(TICKS_PER_SEC - 1)) begin
        next_s.sub_sec = 7'd0;
        next_s.tod = (s.tod == 17'(SECS_PER_DAY - 1)) ? 17'd0
                                                      : s.tod + 17'd1;
      end else begin
        next_s.sub_sec = s.sub_sec + 7'd1;
      end
    end
    if (tel.time_valid && tel.time_value < 17'(SECS_PER_DAY)) begin
      next_s.tod       = tel.time_value;
      next_s.sub_sec   = 7'd0;
      next_s.tod_valid = 1'b1;
    end

    // linear fade, up to four steps per tick from full-range time
    if (s.tick && s.level != s.target) begin
      if (s.fade_ticks == 16'd0) begin
        next_s.level = s.target;
      end else begin
        acc = s.fade_acc + 16'(FULL_SCALE);
        next_s.fade_acc = acc;
        while_loop: for (int i = 0; i < 4; i++) begin
          if (next_s.fade_acc >= s.fade_ticks &&
              next_s.level != s.target) begin
            next_s.fade_acc = next_s.fade_acc - s.fade_ticks;
            next_s.level = (s.target > next_s.level) ? next_s.level + 8'd1
                                                     : next_s.level - 8'd1;
          end
        end
      end
    end

    // lock function
    if (tel.lock_valid) begin
      if ((tel.lock_value == lock_pol) && !s.locked) begin
        next_s.locked    = 1'b1;
        next_s.saved     = s.target;
        next_s.last_seen = 1'b0;
        lock_evt = 1'b1;
        if (start_dim) begin
          next_s.target = start_val;
        end
      end else if ((tel.lock_value != lock_pol) && s.locked) begin
        next_s.locked = 1'b0;
        lock_evt = 1'b1;
        case (end_mode)
          END_DIM:     next_s.target = end_val;
          END_RESTORE: next_s.target = s.saved;
          END_LAST: begin
            if (s.last_seen)
              next_s.target = s.last_tel;
          end
          default: ;
        endcase
      end
    end
    if (tel.prio_valid && s.locked)
      next_s.target = tel.prio_value;
    if (tel.normal_valid) begin
      if (!s.locked) begin
        next_s.target = tel.normal_value;
      end else if (end_mode == END_LAST) begin
        next_s.last_tel  = tel.normal_value;
        next_s.last_seen = 1'b1;
      end
      // otherwise dropped while locked
    end

    // manual interruption
    if (tel.manual && !s.locked && s.running && !s.suspended) begin
      next_s.suspended = 1'b1;
      next_s.off_cnt   = 32'd0;
    end

    // suspend object
    if (tel.suspend_valid && !s.locked) begin
      if (tel.suspend_value) begin
        next_s.suspended = s.running;
      end else if (s.suspended && s.seq_on) begin
        next_s.suspended = 1'b0;
        act = 1'b1;
        uncond = 1'b1;
        act_idx = res_step;
      end
    end

    // off-time resume
    if (s.suspended && s.seq_on && !s.locked && res_mode == RES_OFFTIME &&
        s.tick) begin
      next_s.off_cnt = s.off_cnt + 32'd1;
      if (s.off_cnt >= s.seq_cfg2) begin
        next_s.suspended = 1'b0;
        act = 1'b1;
        uncond = 1'b1;
        act_idx = res_step;
      end
    end

    // sequencer on/off
    if (tel.onoff_valid && !s.locked) begin
      if (tel.onoff_value == onoff_pol) begin
        next_s.seq_on = 1'b1;
        if (s.suspended) begin
          next_s.suspended = 1'b0;
          act = 1'b1;
          uncond = 1'b1;
          act_idx = res_step;
        end else if (on_run) begin
          act = 1'b1;
          uncond = 1'b1;
          act_idx = on_step;
        end
      end else begin
        next_s.seq_on  = 1'b0;
        next_s.running = 1'b0;
        case (off_mode)
          OFF_STEP: begin
            act = 1'b1;
            uncond = 1'b1;
            act_idx = off_step;
          end
          OFF_STOP: next_s.target = s.level;
          default: ;
        endcase
      end
    end

    // conditional step activations, blocked while off or locked
    if (s.seq_on && !s.locked && !act) begin
      if (tel.step_valid && tel.step_index < num_steps &&
          steps[tel.step_index].tel_en) begin
        act = 1'b1;
        act_idx = tel.step_index;
        seq_rst = !tel.step_value;
      end else if (tel.scene_valid) begin
        for (int i = NUM_STEPS - 1; i >= 0; i--) begin
          if (i < num_steps && steps[i].scene_en &&
              steps[i].scene_in == tel.scene_value) begin
            act = 1'b1;
            act_idx = 5'(i);
          end
        end
      end else if (s.tod_valid && s.tick && s.sub_sec == 7'd0) begin
        for (int i = NUM_STEPS - 1; i >= 0; i--) begin
          if (i < num_steps && steps[i].time_mode == START_TIME &&
              steps[i].start_sec == s.tod) begin
            act = 1'b1;
            act_idx = 5'(i);
          end
        end
      end
      if (act && s.suspended && res_mode != RES_NEXT_STEP)
        act = 1'b0;
      if (act)
        next_s.suspended = 1'b0;
    end

    // wait-interval chaining from the previous step
    if (s.running && !s.suspended && s.seq_on && !s.locked && !act &&
        s.tick) begin
      next_s.wait_cnt = s.wait_cnt + 32'd1;
      if (32'(s.cur) + 32'd1 < 32'(num_steps) && s.cur != 5'd31) begin
        st = steps[s.cur + 5'd1];
        if (st.time_mode == START_WAIT &&
            s.wait_cnt >= {15'd0, st.start_sec} * 32'(TICKS_PER_SEC)) begin
          act = 1'b1;
          act_idx = s.cur + 5'd1;
        end
      end
    end

    // execute activated step
    if (act && (uncond || act_idx < num_steps)) begin
      st = steps[act_idx];
      next_s.running  = 1'b1;
      next_s.cur      = act_idx;
      next_s.wait_cnt = 32'd0;
      case (st.action)
        ACT_LOOP: begin
          if (s.loops_done < st.loop_cnt) begin
            next_s.loops_done = s.loops_done + 8'd1;
            next_s.cur = st.loop_to - 5'd1;
            if (st.loop_to == 5'd0)
              next_s.cur = 5'd0;
          end else begin
            next_s.loops_done = 8'd0;
          end
        end
        ACT_SCENE: begin
          next_s.scene_v = 1'b1;
          next_s.scene   = st.param[5:0];
        end
        ACT_BRIGHT: begin
          next_s.target     = st.param;
          next_s.fade_ticks = st.fade_ticks;
          next_s.fade_acc   = 16'd0;
        end
        default: ;
      endcase
    end
    // off telegram runs the step but leaves the sequence idle
    if (act && seq_rst) begin
      next_s.running    = 1'b0;
      next_s.loops_done = 8'd0;
    end
    if (lock_evt)
      next_s.fade_acc = 16'd0;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.lock_cfg <= RESET_LOCK_CFG;
      s.seq_cfg  <= RESET_SEQ_CFG;
      s.seq_cfg2 <= RESET_SEQ_CFG2;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready   = !s.aw_got;
  assign s_axi_wready    = !s.w_got;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_arready   = !s.rvalid;
  assign s_axi_rvalid    = s.rvalid;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign brightness      = s.level;
  assign scene_out_valid = s.scene_v;
  assign scene_out       = s.scene;

endmodule // dimmer_seq

// [dv/dimmer_seq_monitor.sv]
module dimmer_seq_monitor
  import dimmer_seq_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // outputs
  input wire logic [7:0]  brightness,
  input wire logic        scene_out_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------
  // tick spacing helper
  // ------------------------------------------------
  logic [18:0] since;
  logic [7:0]  prev;
  // saturates so a long idle never wraps into a false fail
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since <= 19'h0;
      prev  <= 8'h0;
    end else begin
      prev  <= brightness;
      since <= (brightness != prev) ? 19'h0 :
               (&since) ? since : since + 19'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  a_wr_resp_time: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after accept");
  a_wr_bad_addr: assert property (s_wr_take ##0 (s_axi_awaddr > 8'h1c)
    |-> ##2 s_axi_bresp == 2'b10) else $error("unmapped write not refused");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_rd_resp_time: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after accept");
  a_rd_bad_addr: assert property (s_rd_take ##0 (s_axi_araddr > 8'h1c)
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_busy_stall: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  a_scene_pulse: assert property (scene_out_valid |=> !scene_out_valid)
    else $error("scene strobe longer than one cycle");
  a_ramp_tick: assert property (brightness != prev
    |-> since >= TICK_CYCLES - 2) else $error("level moved off tick");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn
    |=> brightness == 8'h0 && !scene_out_valid && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
endmodule // dimmer_seq_monitor

bind dimmer_seq dimmer_seq_monitor mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .brightness,
  .scene_out_valid);

// [dv/dimmer_seq_bus.sv]
module dimmer_seq_bus
  import dimmer_seq_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // telegrams to the channel
  output telegram_type    tel,
  // scenes from the channel
  input  wire logic       scene_out_valid,
  input  wire logic [5:0] scene_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int         n_scene;
  logic [5:0] last_scene;
  initial begin
    tel = '0;
    n_scene = 0;
    last_scene = 6'h0;
  end
  // every scene the channel sends
  always @(posedge aclk) begin
    if (scene_out_valid) begin
      n_scene++;
      last_scene <= scene_out;
    end
  end
  // one-cycle telegram; stale values garbled once the strobe is gone
  task automatic send(input telegram_type t);
    telegram_type idle;
    idle = ~t;
    {idle.normal_valid, idle.manual, idle.lock_valid, idle.prio_valid} = 4'h0;
    {idle.suspend_valid, idle.onoff_valid, idle.step_valid} = 3'h0;
    {idle.scene_valid, idle.time_valid} = 2'h0;
    @(posedge aclk);
    tel <= t;
    @(posedge aclk);
    tel <= idle;
    repeat (6) @(posedge aclk);
  endtask
endmodule // dimmer_seq_bus

// [dv/dimmer_lock_and_step_sequencer_tb.sv]
module dimmer_lock_and_step_sequencer_tb import dimmer_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic         aclk, aresetn, scene_out_valid;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [7:0]   s_axi_awaddr, s_axi_araddr, brightness;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [5:0]   scene_out;
  telegram_type tel;
  int           err_total, n_compared;
  dimmer_seq uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .tel, .brightness, .scene_out_valid,
    .scene_out);
  dimmer_seq_bus bus (.aclk, .tel, .scene_out_valid, .scene_out);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    // a late ready now and then keeps the hold checks alive
    s_axi_bready  <= 1'($urandom_range(1));
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    chk({38'h0, s_axi_bresp}, {38'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'($urandom_range(1));
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    chk({6'h0, s_axi_rresp, s_axi_rdata & m}, {6'h0, r, e});
  endtask
  // kinds: 0 lock 1 on/off 2 step 3 scene 4 suspend 5 manual 6 time
  task automatic tg(input int k, input logic [16:0] v);
    telegram_type t;
    t = '0;
    case (k)
      0: {t.lock_valid, t.lock_value} = {1'b1, v[0]};
      1: {t.onoff_valid, t.onoff_value} = {1'b1, v[0]};
      2: {t.step_valid, t.step_value, t.step_index} = {1'b1, v[5:0]};
      3: {t.scene_valid, t.scene_value} = {1'b1, v[5:0]};
      4: {t.suspend_valid, t.suspend_value} = {1'b1, v[0]};
      5: t.manual = 1'b1;
      default: {t.time_valid, t.time_value} = {1'b1, v};
    endcase
    bus.send(t);
  endtask
  function automatic step_cfg_type mk(input logic [5:0] s,
                                      input logic [7:0] p, action_type a);
    step_cfg_type c;
    c          = '0;
    c.tel_en   = 1'b1;
    c.scene_en = 1'b1;
    c.scene_in = s;
    c.action   = a;
    c.param    = p;
    return c;
  endfunction
  task automatic prog(input int k, input step_cfg_type c);
    wr(ADDR_STEP_SEL, 32'(k), 2'b00);
    wr(ADDR_STEP_W0, c[31:0], 2'b00);
    wr(ADDR_STEP_W1, c[63:32], 2'b00);
  endtask
  task automatic scn(input int ns, input logic [5:0] s);
    chk(40'(bus.n_scene), 40'(ns));
    chk(40'(bus.last_scene), 40'(s));
  endtask
  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    wrap_up();
  end
  initial begin
    int          n, ns, k;
    logic [5:0]  sc [8];
    logic [16:0] tod;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    n_compared = 0;
    void'($urandom(77461));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_LOCK_CFG, '1, RESET_LOCK_CFG, 2'b00);
    rd(ADDR_SEQ_CFG, '1, RESET_SEQ_CFG, 2'b00);
    rd(ADDR_SEQ_CFG2, '1, RESET_SEQ_CFG2, 2'b00);
    rd(8'h40, '1, 32'h0, 2'b10);
    wr(8'h40, 32'hffff_ffff, 2'b10);
    rd(ADDR_STATUS, 32'h10, 32'h0, 2'b00);
    tod = 17'($urandom_range(86399));
    tg(6, tod);
    rd(ADDR_STATUS, 32'h10, 32'h10, 2'b00);
    rd(ADDR_TIME, 32'h1ffff, 32'(tod), 2'b00);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_LOCK_CFG, 32'(p), 2'b00);
      tg(0, 17'(1 - p));
      rd(ADDR_STATUS, 32'h1, 32'h0, 2'b00);
      tg(0, 17'(p));
      rd(ADDR_STATUS, 32'h1, 32'h1, 2'b00);
      tg(0, 17'(1 - p));
      rd(ADDR_STATUS, 32'h1, 32'h0, 2'b00);
    end
    n = 2 + $urandom_range(4);
    for (int i = 0; i <= n; i++) begin
      sc[i] = 6'($urandom);
      prog(i, mk(6'(i + 1), {2'b00, sc[i]}, ACT_SCENE));
    end
    wr(ADDR_SEQ_CFG, 32'h2000 | 32'(n), 2'b00);
    tg(1, 17'h1);
    rd(ADDR_STATUS, 32'h2, 32'h2, 2'b00);
    ns = 0;
    for (int i = 0; i < n; i++) begin
      tg(2, 17'(32 + i));
      ns++;
      scn(ns, sc[i]);
    end
    k = $urandom_range(n - 1);
    tg(3, 17'(k + 1));
    ns++;
    scn(ns, sc[k]);
    tg(2, 17'(32 + n));
    scn(ns, sc[k]);
    tg(4, 17'h1);
    rd(ADDR_STATUS, 32'h8, 32'h8, 2'b00);
    tg(4, 17'h0);
    rd(ADDR_STATUS, 32'h8, 32'h0, 2'b00);
    ns++;
    scn(ns, sc[0]);
    tg(5, 17'h0);
    rd(ADDR_STATUS, 32'h8, 32'h8, 2'b00);
    tg(4, 17'h0);
    rd(ADDR_STATUS, 32'h8, 32'h0, 2'b00);
    ns++;
    scn(ns, sc[0]);
    tg(0, 17'h1);
    tg(2, 17'(32));
    tg(3, 17'h1);
    scn(ns, sc[0]);
    tg(0, 17'h0);
    tg(1, 17'h0);
    rd(ADDR_STATUS, 32'h2, 32'h0, 2'b00);
    tg(2, 17'(32));
    scn(ns, sc[0]);
    prog(0, mk(6'h1, 8'h0, ACT_NONE));
    tg(1, 17'h1);
    tg(2, 17'(32));
    scn(ns, sc[0]);
    chk(40'(brightness), 40'h0);
    tg(2, 17'h0);
    rd(ADDR_STATUS, 32'h4, 32'h0, 2'b00);
    wr(ADDR_SEQ_CFG, 32'h0090_e000 | 32'(n), 2'b00);
    tg(1, 17'h0);
    ns++;
    scn(ns, sc[2]);
    tg(1, 17'h1);
    ns++;
    scn(ns, sc[1]);
    wrap_up();
  end
endmodule // dimmer_lock_and_step_sequencer_tb
